// file: iotic_top.sv
// io transfer interlock control: wishbone registers, transfer engine, device and memory ports
`timescale 1ns/1ps
module iotic_top
	import iotic_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic [ADR_W-1:0]  wb_adr_i,
	input  wire logic [WORD_W-1:0] wb_dat_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_we_i,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	output logic [WORD_W-1:0]      wb_dat_o,
	output logic                   wb_ack_o,
	output logic                   irq_o,
	input  wire logic              man_rst_i,
	output logic                   interlock_o,
	output logic [CODE_W-1:0]      dev_sel_o,
	output logic                   dev_dir_in_o,
	input  wire logic              dev_exists_i,
	input  wire logic              dev_ready_i,
	input  wire logic              dev_prepared_i,
	input  wire logic              dev_dir_ok_i,
	input  wire logic              dev_in_valid_i,
	input  wire logic [WORD_W-1:0] dev_in_data_i,
	output logic                   dev_in_ready_o,
	output logic                   dev_out_valid_o,
	output logic [WORD_W-1:0]      dev_out_data_o,
	input  wire logic              dev_out_ready_i,
	output logic                   mem_req_o,
	output logic                   mem_we_o,
	output logic [HALF_W-1:0]      mem_addr_o,
	output logic [WORD_W-1:0]      mem_wdata_o,
	input  wire logic [WORD_W-1:0] mem_rdata_i,
	input  wire logic              mem_ack_i
);
	typedef struct packed {
		iotic_st_t         st;
		logic              interlock;
		logic              locked;
		logic              is_read;
		logic              mode17;
		logic [CODE_W-1:0] dev_sel;
		logic [HALF_W-1:0] addr;
		logic [HALF_W-1:0] operand;
		logic [WORD_W-1:0] xfer;
		logic [WORD_W-1:0] result;
		logic              ack;
		logic [WORD_W-1:0] rdata;
		logic              mem_req;
		logic              mem_we;
		logic [HALF_W-1:0] mem_addr;
		logic              in_ready;
		logic              out_valid;
	} iotic_state_t;

	function automatic logic [WORD_W-1:0] wb_merge(input logic [WORD_W-1:0] old_w,
		input logic [WORD_W-1:0] new_w, input logic [3:0] sel);
		logic [WORD_W-1:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_w & ~m) | (new_w & m);
	endfunction

	function automatic logic [WORD_W-1:0] csw_word(input logic [WC_W-1:0] wc, input logic m17);
		logic [WORD_W-1:0] w;
		w = '0;
		if (m17) begin
			w[WORD_W-1] = wc[WC_W-1];
			w[HALF_W-1:0] = wc[HALF_W-1:0];
		end else begin
			w[HALF_W-1:0] = {wc[WC_W-1], wc[HALF_W-2:0]};
		end
		return w;
	endfunction

	iotic_state_t      s_reg, s_next;
	logic [WC_W-1:0]   wc_val;
	logic              wc_carry;
	logic              wc_load;
	logic              wc_step;
	logic              word_done;
	logic              clr_il;
	logic [IRQ_W-1:0]  irq_ev;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	logic              irq_clr_we;
	logic              irq_mask_we;
	logic [WORD_W-1:0] w1c_bits;
	logic [WORD_W-1:0] mask_merged;
	logic [WORD_W-1:0] oper_merged;
	logic [WORD_W-1:0] ctrl_merged;
	logic [ADR_W-1:0]  adr;
	logic              req;
	logic              cmd_wr;
	logic              cmd_io;
	logic              cmd_go;
	logic              dev_ok;
	logic              sel_self;
	iotic_op_t         cmd_op;
	logic [CODE_W-1:0] cmd_code;

	assign adr = {wb_adr_i[ADR_W-1:2], 2'b00};
	assign req = wb_cyc_i & wb_stb_i & ~s_reg.ack;
	assign cmd_wr = req & wb_we_i & (adr == ADR_CMD);
	assign cmd_op = iotic_op_t'(wb_dat_i[3:0]);
	assign cmd_code = wb_dat_i[CMD_CODE_LSB +: CODE_W];
	assign cmd_io = (cmd_op == OP_SELECT) | (cmd_op == OP_LOAD_ADDR) | (cmd_op == OP_READ) | (cmd_op == OP_WRITE);
	// holding ack is the stall: the master waits until the interlock drops
	assign cmd_go = cmd_wr & ~(cmd_io & s_reg.interlock);
	assign dev_ok = dev_exists_i & dev_ready_i & dev_prepared_i & dev_dir_ok_i;
	assign sel_self = (s_reg.dev_sel == SEL_XFER_REG);
	assign w1c_bits = wb_merge('0, wb_dat_i, wb_sel_i);
	assign mask_merged = wb_merge({{(WORD_W-IRQ_W){1'b0}}, irq_mask}, wb_dat_i, wb_sel_i);
	assign oper_merged = wb_merge({{HALF_W{1'b0}}, s_reg.operand}, wb_dat_i, wb_sel_i);
	assign ctrl_merged = wb_merge({{(WORD_W-1){1'b0}}, s_reg.mode17}, wb_dat_i, wb_sel_i);

	iotic_wcount i_iotic_wcount (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.load_i  (wc_load),
		.count_i (s_reg.operand),
		.step_i  (wc_step),
		.wc_o    (wc_val),
		.carry_o (wc_carry)
	);

	iotic_irq i_iotic_irq (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.event_i   (irq_ev),
		.clr_we_i  (irq_clr_we),
		.clr_i     (w1c_bits[IRQ_W-1:0]),
		.mask_we_i (irq_mask_we),
		.mask_i    (mask_merged[IRQ_W-1:0]),
		.status_o  (irq_stat),
		.mask_o    (irq_mask),
		.irq_o     (irq_o)
	);

	always_comb begin
		s_next = s_reg;
		s_next.ack = 1'b0;
		wc_load = 1'b0;
		wc_step = 1'b0;
		word_done = 1'b0;
		clr_il = 1'b0;
		irq_ev = IRQ_RST;
		irq_clr_we = 1'b0;
		irq_mask_we = 1'b0;
		case (s_reg.st)
			ST_IDLE: begin
			end
			ST_PRESTEP: begin
				wc_step = 1'b1;
				s_next.st = s_reg.is_read ? ST_DEV_IN : ST_MEM_GET;
			end
			ST_DEV_IN: begin
				// a taken handshake wins over a device that just went away
				if (sel_self || (s_reg.in_ready && dev_in_valid_i)) begin
					if (!sel_self) begin
						s_next.xfer = dev_in_data_i;
					end
					s_next.in_ready = 1'b0;
					s_next.mem_req = 1'b1;
					s_next.mem_we = 1'b1;
					s_next.mem_addr = s_reg.addr;
					s_next.st = ST_MEM_PUT;
				end else if (!dev_ok) begin
					s_next.in_ready = 1'b0;
					irq_ev[IRQ_FAULT] = 1'b1;
				end else begin
					s_next.in_ready = 1'b1;
				end
			end
			ST_MEM_PUT: begin
				if (mem_ack_i) begin
					s_next.mem_req = 1'b0;
					word_done = 1'b1;
				end
			end
			ST_MEM_GET: begin
				if (s_reg.mem_req) begin
					if (mem_ack_i) begin
						s_next.mem_req = 1'b0;
						if (sel_self) begin
							s_next.xfer = s_reg.xfer | mem_rdata_i;
							word_done = 1'b1;
						end else begin
							s_next.xfer = mem_rdata_i;
							s_next.out_valid = 1'b1;
							s_next.st = ST_DEV_OUT;
						end
					end
				end else if (sel_self || dev_ok) begin
					s_next.mem_req = 1'b1;
					s_next.mem_we = 1'b0;
					s_next.mem_addr = s_reg.addr;
				end else begin
					irq_ev[IRQ_FAULT] = 1'b1;
				end
			end
			ST_DEV_OUT: begin
				if (dev_out_ready_i) begin
					s_next.out_valid = 1'b0;
					word_done = 1'b1;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase
		if (word_done) begin
			wc_step = 1'b1;
			if (!s_reg.locked) begin
				s_next.addr = s_reg.addr + ADDR_ONE;
			end
			s_next.st = s_reg.is_read ? ST_DEV_IN : ST_MEM_GET;
		end
		if ((word_done || s_reg.st == ST_PRESTEP) && !sel_self) begin
			s_next.xfer = '0;
		end
		if (wc_step && wc_carry) begin
			// with a nonzero count no word moved means no carry, so a hung device keeps it set; a zero count carries at the prestep
			s_next.interlock = 1'b0;
			s_next.locked = 1'b0;
			s_next.st = ST_IDLE;
			irq_ev[IRQ_DONE] = 1'b1;
		end
		if (req) begin
			s_next.rdata = '0;
			if (wb_we_i) begin
				s_next.ack = cmd_go | (adr != ADR_CMD);
				case (adr)
					ADR_OPERAND: s_next.operand = oper_merged[HALF_W-1:0];
					ADR_CTRL: s_next.mode17 = ctrl_merged[CTRL_MODE17];
					ADR_IRQ_STAT: irq_clr_we = 1'b1;
					ADR_IRQ_MASK: irq_mask_we = 1'b1;
					default: begin
					end
				endcase
			end else begin
				s_next.ack = 1'b1;
				case (adr)
					ADR_OPERAND: s_next.rdata[HALF_W-1:0] = s_reg.operand;
					ADR_RESULT: s_next.rdata = s_reg.result;
					ADR_STATUS: s_next.rdata[STAT_W-1:0] = {s_reg.dev_sel, s_reg.st, s_reg.locked, s_reg.interlock};
					ADR_ADDR: s_next.rdata[HALF_W-1:0] = s_reg.addr;
					ADR_WC: s_next.rdata[WC_W-1:0] = wc_val;
					ADR_XFER: s_next.rdata = s_reg.xfer;
					ADR_IRQ_STAT: s_next.rdata[IRQ_W-1:0] = irq_stat;
					ADR_IRQ_MASK: s_next.rdata[IRQ_W-1:0] = irq_mask;
					ADR_CTRL: s_next.rdata[CTRL_MODE17] = s_reg.mode17;
					default: begin
					end
				endcase
			end
		end
		if (cmd_go) begin
			case (cmd_op)
				OP_SELECT: begin
					s_next.dev_sel = cmd_code;
					s_next.xfer = '0;
				end
				OP_LOAD_ADDR: s_next.addr = s_reg.operand;
				OP_READ, OP_WRITE: begin
					wc_load = 1'b1;
					s_next.interlock = 1'b1;
					s_next.is_read = (cmd_op == OP_READ);
					s_next.st = ST_PRESTEP;
				end
				OP_COPY_WC: s_next.result = csw_word(wc_val, s_reg.mode17);
				OP_BRANCH: begin
					s_next.result = '0;
					if (cmd_code == BR_IO_BUSY && s_reg.interlock) begin
						s_next.result = {BR_TAKEN, s_reg.operand};
					end
				end
				OP_PER: begin
					if (cmd_code == PER_LOCK_ADR) begin
						s_next.locked = 1'b1;
					end
					clr_il = (cmd_code == PER_CLEAR_IL);
				end
				default: begin
				end
			endcase
		end
		// forced clear abandons any memory or device handshake in flight
		if (clr_il || man_rst_i) begin
			s_next.interlock = 1'b0;
			s_next.locked = 1'b0;
			s_next.st = ST_IDLE;
			s_next.mem_req = 1'b0;
			s_next.in_ready = 1'b0;
			s_next.out_valid = 1'b0;
			irq_ev[IRQ_CLEAR] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_dat_o = s_reg.rdata;
	assign wb_ack_o = s_reg.ack;
	assign interlock_o = s_reg.interlock;
	assign dev_sel_o = s_reg.dev_sel;
	assign dev_dir_in_o = s_reg.is_read;
	assign dev_in_ready_o = s_reg.in_ready;
	assign dev_out_valid_o = s_reg.out_valid;
	assign dev_out_data_o = s_reg.xfer;
	assign mem_req_o = s_reg.mem_req;
	assign mem_we_o = s_reg.mem_we;
	assign mem_addr_o = s_reg.mem_addr;
	assign mem_wdata_o = s_reg.xfer;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence rw_start_s;
		cmd_go && (cmd_op == OP_READ || cmd_op == OP_WRITE) && !man_rst_i ##1 s_reg.st == ST_PRESTEP;
	endsequence
	sequence self_word_s;
		s_reg.st == ST_DEV_IN && sel_self && !man_rst_i && !clr_il;
	endsequence

	stall_hold_a: assert property (cmd_wr && cmd_io && interlock_o |=> !wb_ack_o)
		else $error("io instruction acknowledged while interlock set");
	keep_interlock_a: assert property (interlock_o && !(wc_step && wc_carry) && !man_rst_i && !clr_il
		|=> interlock_o)
		else $error("interlock dropped without carry or clear");
	manual_clear_a: assert property (man_rst_i |=> !interlock_o && !mem_req_o && !dev_in_ready_o)
		else $error("manual reset did not clear interlock");
	hangup_stall_a: assert property (s_reg.st == ST_DEV_IN && !sel_self && !dev_ok && !dev_in_ready_o
		|=> !dev_in_ready_o && !mem_req_o)
		else $error("transfer moved with device not usable");
	load_count_a: assert property (rw_start_s |-> interlock_o && wc_val == ~{1'b0, $past(s_reg.operand)})
		else $error("word counter not loaded from count");
	prestep_a: assert property (s_reg.st == ST_PRESTEP && !wc_carry |=> wc_val == $past(wc_val) + WC_ONE)
		else $error("counter not stepped before first word");
	csw_seventeen_a: assert property (cmd_go && cmd_op == OP_COPY_WC && s_reg.mode17
		|=> s_reg.result[WORD_W-1] == $past(wc_val[WC_W-1]))
		else $error("left sign does not follow counter");
	csw_sixteen_a: assert property (cmd_go && cmd_op == OP_COPY_WC && !s_reg.mode17
		|=> s_reg.result[HALF_W-1] == $past(wc_val[WC_W-1]) && s_reg.result[WORD_W-1] == 1'b0)
		else $error("right sign does not follow counter");
	select_clear_a: assert property (cmd_go && cmd_op == OP_SELECT
		|=> s_reg.xfer == '0 && dev_sel_o == $past(cmd_code))
		else $error("select did not clear transfer register");
	self_source_a: assert property (self_word_s |=> mem_req_o && mem_we_o && mem_wdata_o == $past(s_reg.xfer))
		else $error("selected register word not stored");
	self_or_a: assert property (s_reg.st == ST_MEM_GET && s_reg.mem_req && mem_ack_i && sel_self
		|=> s_reg.xfer == ($past(s_reg.xfer) | $past(mem_rdata_i)))
		else $error("written word not ORed into register");
	force_clear_a: assert property (cmd_go && cmd_op == OP_PER && cmd_code == PER_CLEAR_IL |=> !interlock_o)
		else $error("clear interlock code had no effect");
	lock_hold_a: assert property (s_reg.locked && interlock_o |=> $stable(s_reg.addr))
		else $error("locked address counter moved");
	branch_a: assert property (cmd_go && cmd_op == OP_BRANCH && cmd_code == BR_IO_BUSY
		|=> s_reg.result == ($past(interlock_o) ? {BR_TAKEN, $past(s_reg.operand)} : {WORD_W{1'b0}}))
		else $error("branch result wrong for interlock state");
	addr_step_a: assert property (word_done && !s_reg.locked |=> s_reg.addr == $past(s_reg.addr) + ADDR_ONE)
		else $error("address counter did not advance");
endmodule

// file: iotic_pkg.sv
// constants and types for the io transfer interlock control
package iotic_pkg;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int WC_W = 17;
	localparam int CODE_W = 6;
	localparam int ADR_W = 8;
	localparam int IRQ_W = 3;
	localparam int STAT_W = 11;
	localparam int CMD_CODE_LSB = 8;
	localparam int CTRL_MODE17 = 0;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_CLEAR = 1;
	localparam int IRQ_FAULT = 2;
	// select and sub codes, octal 04, 14, 27, 75
	localparam logic [CODE_W-1:0] SEL_XFER_REG = 6'h04;
	localparam logic [CODE_W-1:0] BR_IO_BUSY   = 6'h0c;
	localparam logic [CODE_W-1:0] PER_CLEAR_IL = 6'h17;
	localparam logic [CODE_W-1:0] PER_LOCK_ADR = 6'h3d;
	localparam logic [ADR_W-1:0] ADR_CMD      = 8'h00;
	localparam logic [ADR_W-1:0] ADR_OPERAND  = 8'h04;
	localparam logic [ADR_W-1:0] ADR_RESULT   = 8'h08;
	localparam logic [ADR_W-1:0] ADR_STATUS   = 8'h0c;
	localparam logic [ADR_W-1:0] ADR_ADDR     = 8'h10;
	localparam logic [ADR_W-1:0] ADR_WC       = 8'h14;
	localparam logic [ADR_W-1:0] ADR_XFER     = 8'h18;
	localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h1c;
	localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h20;
	localparam logic [ADR_W-1:0] ADR_CTRL     = 8'h24;
	localparam logic [WC_W-1:0] WC_RST = 17'h00000;
	localparam logic [WC_W-1:0] WC_ONE = 17'h00001;
	localparam logic [HALF_W-1:0] ADDR_ONE = 16'h0001;
	localparam logic [HALF_W-1:0] BR_TAKEN = 16'h0001;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
	typedef enum logic [3:0] {
		OP_NONE      = 4'h0,
		OP_SELECT    = 4'h1,
		OP_LOAD_ADDR = 4'h2,
		OP_READ      = 4'h3,
		OP_WRITE     = 4'h4,
		OP_COPY_WC   = 4'h5,
		OP_BRANCH    = 4'h6,
		OP_PER       = 4'h7
	} iotic_op_t;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_PRESTEP = 3'h1,
		ST_DEV_IN  = 3'h3,
		ST_MEM_PUT = 3'h2,
		ST_MEM_GET = 3'h5,
		ST_DEV_OUT = 3'h4
	} iotic_st_t;
endpackage

// file: iotic_wcount.sv
// word counter: ones' complement count that carries out past minus zero
`timescale 1ns/1ps
module iotic_wcount
	import iotic_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              load_i,
	input  wire logic [HALF_W-1:0] count_i,
	input  wire logic              step_i,
	output logic [WC_W-1:0]        wc_o,
	output logic                   carry_o
);
	typedef struct packed {
		logic [WC_W-1:0] wc;
	} iotic_wc_state_t;
	iotic_wc_state_t s_reg, s_next;
	// carry is not gated by step so the caller can use it without a loop
	assign carry_o = &s_reg.wc;
	always_comb begin
		s_next = s_reg;
		if (load_i) begin
			s_next.wc = ~{1'b0, count_i};
		end else if (step_i) begin
			s_next.wc = carry_o ? WC_RST : s_reg.wc + WC_ONE;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign wc_o = s_reg.wc;
endmodule

// file: iotic_irq.sv
// sticky interrupt status with mask and one level output
`timescale 1ns/1ps
module iotic_irq
	import iotic_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [IRQ_W-1:0] event_i,
	input  wire logic             clr_we_i,
	input  wire logic [IRQ_W-1:0] clr_i,
	input  wire logic             mask_we_i,
	input  wire logic [IRQ_W-1:0] mask_i,
	output logic [IRQ_W-1:0]      status_o,
	output logic [IRQ_W-1:0]      mask_o,
	output logic                  irq_o
);
	typedef struct packed {
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic             irq;
	} iotic_irq_state_t;
	iotic_irq_state_t s_reg, s_next;
	always_comb begin
		s_next = s_reg;
		// a new event beats a clear in the same cycle
		s_next.status = (s_reg.status & ~(clr_we_i ? clr_i : IRQ_RST)) | event_i;
		if (mask_we_i) begin
			s_next.mask = mask_i;
		end
		s_next.irq = |(s_next.status & s_next.mask);
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign status_o = s_reg.status;
	assign mask_o = s_reg.mask;
	assign irq_o = s_reg.irq;
endmodule

// file: iotic_dev_model.sv
// peripheral and core memory model facing the transfer engine
`timescale 1ns/1ps
module iotic_dev_model
	import iotic_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              in_ready_i,
	output logic                   in_valid_o,
	output logic [WORD_W-1:0]      in_data_o,
	input  wire logic              out_valid_i,
	input  wire logic [WORD_W-1:0] out_data_i,
	output logic                   out_ready_o,
	input  wire logic              req_i,
	input  wire logic              we_i,
	input  wire logic [HALF_W-1:0] addr_i,
	input  wire logic [WORD_W-1:0] wdata_i,
	output logic [WORD_W-1:0]      rdata_o,
	output logic                   ack_o
);
	logic [WORD_W-1:0] mem [256];
	logic [WORD_W-1:0] word_reg;
	logic [WORD_W-1:0] out_last;
	int                out_cnt;
	// idle data is the inverse so a stale word never passes for a fresh one
	assign in_data_o = in_valid_o ? word_reg : ~word_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_valid_o <= 1'b0;
			word_reg <= 32'hd0000000;
			out_ready_o <= 1'b0;
			ack_o <= 1'b0;
			rdata_o <= '0;
			out_cnt <= 0;
			for (int i = 0; i < 256; i++) mem[i] <= 32'h1 << i[4:0];
		end else begin
			// slow source and sink: a gap cycle after every word
			if (in_valid_o && in_ready_i) begin
				in_valid_o <= 1'b0;
				word_reg <= word_reg + 32'h1;
			end else begin
				in_valid_o <= 1'b1;
			end
			out_ready_o <= ~out_ready_o;
			if (out_valid_i && out_ready_o) begin
				out_cnt <= out_cnt + 1;
				out_last <= out_data_i;
			end
			ack_o <= req_i && !ack_o;
			if (req_i && !ack_o) begin
				if (we_i) mem[addr_i[7:0]] <= wdata_i;
				rdata_o <= mem[addr_i[7:0]];
			end else begin
				rdata_o <= ~rdata_o;
			end
		end
	end
endmodule

// file: tb_io_transfer_interlock_control.sv
// self-checking bench for the io transfer interlock control
`timescale 1ns/1ps
module tb_io_transfer_interlock_control;
	import iotic_pkg::*;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	logic [ADR_W-1:0]       wb_adr = '0;
	logic [WORD_W-1:0]      wb_wdat = '0;
	logic                   wb_we = 1'b0;
	logic                   wb_cyc = 1'b0;
	logic                   wb_stb = 1'b0;
	logic                   man_rst = 1'b0;
	logic [3:0]             dev_ok = 4'hf;
	logic [WORD_W-1:0]      rd;
	logic                   released = 1'b0;
	int                     miscompares = 0;
	int                     compares = 0;
	wire logic [WORD_W-1:0] wb_rdat, in_data, out_data, mem_wdata, mem_rdata;
	wire logic              wb_ack, irq, il, dir_in, in_valid, in_ready, out_valid, out_ready, mem_req, mem_we, mem_ack;
	wire logic [CODE_W-1:0] dev_sel;
	wire logic [HALF_W-1:0] mem_addr;
	always #5 clk_i = ~clk_i;
	iotic_top i_iotic_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(4'hf),
		.wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq),
		.man_rst_i(man_rst), .interlock_o(il), .dev_sel_o(dev_sel), .dev_dir_in_o(dir_in),
		.dev_exists_i(dev_ok[0]), .dev_ready_i(dev_ok[1]), .dev_prepared_i(dev_ok[2]), .dev_dir_ok_i(dev_ok[3]),
		.dev_in_valid_i(in_valid), .dev_in_data_i(in_data), .dev_in_ready_o(in_ready), .dev_out_valid_o(out_valid),
		.dev_out_data_o(out_data), .dev_out_ready_i(out_ready), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
	iotic_dev_model i_iotic_dev_model (.clk_i(clk_i), .rst_i(rst_i), .in_ready_i(in_ready), .in_valid_o(in_valid),
		.in_data_o(in_data), .out_valid_i(out_valid), .out_data_i(out_data), .out_ready_o(out_ready),
		.req_i(mem_req), .we_i(mem_we), .addr_i(mem_addr), .wdata_i(mem_wdata), .rdata_o(mem_rdata), .ack_o(mem_ack));
	task automatic check(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// a stalled command simply waits here; only the watchdog ends a hang
	task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [WORD_W-1:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_wdat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack !== 1'b1);
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rc(input string what, input logic [ADR_W-1:0] a, input logic [WORD_W-1:0] exp);
		wb(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask
	task automatic op(input iotic_op_t o, input logic [CODE_W-1:0] c, input logic [HALF_W-1:0] v);
		wb(1'b1, ADR_OPERAND, {16'h0, v});
		wb(1'b1, ADR_CMD, 32'(c) << CMD_CODE_LSB | 32'(o));
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (il !== 1'b0 && n < 500) begin
			@(posedge clk_i);
			n++;
		end
		check("interlock", 32'(il), 32'h0);
	endtask
	task automatic sc_read();
		op(OP_SELECT, 6'h01, 16'h0);
		op(OP_LOAD_ADDR, 6'h0, 16'h0040);
		op(OP_READ, 6'h0, 16'h0003);
		wait_idle();
		for (int i = 0; i < 3; i++) check("word", i_iotic_dev_model.mem[64+i], 32'hd0000000 + 32'(i));
		check("beyond", i_iotic_dev_model.mem[67], 32'h8);
		rc("addr", ADR_ADDR, 32'h43);
		rc("xfer", ADR_XFER, 32'h0);
		rc("done", ADR_IRQ_STAT, 32'h1);
		check("dev_sel", 32'(dev_sel), 32'h1);
		check("dir", 32'(dir_in), 32'h1);
		wb(1'b1, ADR_IRQ_STAT, 32'h7);
		rc("unmapped", 8'hfc, 32'h0);
	endtask
	task automatic sc_hang();
		for (int b = 0; b < 4; b++) begin
			dev_ok <= 4'hf & ~(4'h1 << b);
			op(OP_READ, 6'h0, 16'h0002);
			repeat (20) @(posedge clk_i);
			check("stuck", 32'(il), 32'h1);
			wb(1'b0, ADR_IRQ_STAT, 32'h0);
			check("fault", rd & 32'h4, 32'h4);
			op(OP_PER, PER_CLEAR_IL, 16'h0);
			check("cleared", 32'(il), 32'h0);
			rc("forced", ADR_IRQ_STAT, 32'h6);
		end
		dev_ok <= 4'hf;
		wb(1'b1, ADR_IRQ_MASK, 32'h2);
		check("irq on", 32'(irq), 32'h1);
		wb(1'b1, ADR_IRQ_STAT, 32'h2);
		check("irq off", 32'(irq), 32'h0);
		rc("w1c", ADR_IRQ_STAT, 32'h4);
		wb(1'b1, ADR_IRQ_STAT, 32'h7);
	endtask
	task automatic sc_stall();
		dev_ok <= 4'hd;
		op(OP_READ, 6'h0, 16'h0002);
		op(OP_COPY_WC, 6'h0, 16'h0);
		rc("wc16", ADR_RESULT, 32'h0000fffe);
		wb(1'b1, ADR_CTRL, 32'h1);
		op(OP_COPY_WC, 6'h0, 16'h0);
		rc("wc17", ADR_RESULT, 32'h8000fffe);
		rc("wc", ADR_WC, 32'h1fffe);
		op(OP_BRANCH, BR_IO_BUSY, 16'h1234);
		rc("branch", ADR_RESULT, 32'h00011234);
		fork
			begin
				op(OP_LOAD_ADDR, 6'h0, 16'h0055);
				check("held", 32'(released), 32'h1);
			end
			begin
				repeat (40) @(posedge clk_i);
				released = 1'b1;
				man_rst <= 1'b1;
				@(posedge clk_i);
				man_rst <= 1'b0;
			end
		join
		check("manual", 32'(il), 32'h0);
		rc("loaded", ADR_ADDR, 32'h55);
		op(OP_BRANCH, BR_IO_BUSY, 16'h1234);
		rc("fall", ADR_RESULT, 32'h0);
		wb(1'b1, ADR_CTRL, 32'h0);
		wb(1'b1, ADR_IRQ_STAT, 32'h7);
		dev_ok <= 4'hf;
	endtask
	task automatic sc_xreg();
		op(OP_SELECT, SEL_XFER_REG, 16'h0);
		op(OP_LOAD_ADDR, 6'h0, 16'h0080);
		op(OP_WRITE, 6'h0, 16'h0003);
		wait_idle();
		rc("or", ADR_XFER, 32'h7);
		op(OP_LOAD_ADDR, 6'h0, 16'h0090);
		op(OP_READ, 6'h0, 16'h0002);
		wait_idle();
		check("fill0", i_iotic_dev_model.mem[144], 32'h7);
		check("fill1", i_iotic_dev_model.mem[145], 32'h7);
		check("fill2", i_iotic_dev_model.mem[146], 32'h00040000);
		op(OP_SELECT, SEL_XFER_REG, 16'h0);
		rc("sel clr", ADR_XFER, 32'h0);
	endtask
	task automatic sc_lock();
		int n0;
		op(OP_SELECT, 6'h01, 16'h0);
		op(OP_LOAD_ADDR, 6'h0, 16'h00a4);
		op(OP_PER, PER_LOCK_ADR, 16'h0);
		n0 = i_iotic_dev_model.out_cnt;
		op(OP_WRITE, 6'h0, 16'h0003);
		wait_idle();
		check("out n", 32'(i_iotic_dev_model.out_cnt - n0), 32'h3);
		check("out w", i_iotic_dev_model.out_last, 32'h10);
		rc("frozen", ADR_ADDR, 32'ha4);
		check("dir", 32'(dir_in), 32'h0);
		op(OP_LOAD_ADDR, 6'h0, 16'h00b0);
		op(OP_PER, PER_LOCK_ADR, 16'h0);
		op(OP_READ, 6'h0, 16'h0002);
		wait_idle();
		check("one loc", i_iotic_dev_model.mem[176], 32'hd0000004);
		check("next loc", i_iotic_dev_model.mem[177], 32'h00020000);
		wb(1'b0, ADR_STATUS, 32'h0);
		check("unlock", rd & 32'h2, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		sc_read();
		sc_hang();
		sc_stall();
		sc_xreg();
		sc_lock();
		report_and_stop();
	end
	// whole run needs well under a thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		report_and_stop();
	end
endmodule
